// ### rtl/bmi_lane_ctrl.sv
// byte-lane mask/inversion control: pin sampling, burst sequencing, training store
`timescale 1ns/1ps
`default_nettype none
module bmi_lane_ctrl
  import bmi_pkg::*;
#(
  parameter int LANES = 2,
  parameter int FIFO_DEPTH = 32
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // mode register contents
  input wire logic [7:0] mr3_op,
  input wire logic [7:0] mode_register_thirteen_op,
  // command from the command decoder
  input wire logic cmd_valid,
  input wire bmi_cmd_s cmd,
  // write pins from the host
  input wire logic strobe_pin,
  input wire logic [LANES*LANE_W-1:0] dq_pin_in,
  input wire logic [LANES-1:0] mi_pin_in,
  // read beats from the array
  input wire logic rd_beat_valid,
  input wire logic [LANES*LANE_W-1:0] rd_beat_data,
  input wire logic [LANES-1:0] rd_beat_cal,
  // read side toward the pins
  output logic [LANES*LANE_W-1:0] rd_dq_out,
  output logic rd_dq_valid,
  output logic [LANES-1:0] mi_pin_out,
  output logic [LANES-1:0] mi_pin_oe,
  output logic mi_rx_en,
  // write beats toward the array
  output logic wr_valid,
  output logic [LANES*LANE_W-1:0] wr_data,
  output logic [LANES-1:0] wr_keep,
  // status
  output logic busy,
  output logic illegal_cmd
);

  localparam int PTR_W = $clog2(FIFO_DEPTH);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WRITE,
    ST_READ
  } bmi_state_e;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic strobe_s1_reg; // first stage, read only by the second
  logic strobe_s2_reg; // synced strobe
  logic strobe_d_reg; // previous synced strobe
  logic [LANES*LANE_W-1:0] dq_s1_reg; // first stage
  logic [LANES*LANE_W-1:0] dq_s2_reg; // synced data
  logic [LANES-1:0] mi_s1_reg; // first stage
  logic [LANES-1:0] mi_s2_reg; // synced pin
  logic strobe_edge; // either strobe edge marks a beat

  // two flops on every pin, a third to find strobe edges
  always_ff @(posedge clk)
  begin
    strobe_s1_reg <= strobe_pin;
    strobe_s2_reg <= strobe_s1_reg;
    strobe_d_reg <= strobe_s2_reg;
    dq_s1_reg <= dq_pin_in;
    dq_s2_reg <= dq_s1_reg;
    mi_s1_reg <= mi_pin_in;
    mi_s2_reg <= mi_s1_reg;
  end

  assign strobe_edge = strobe_s2_reg ^ strobe_d_reg;

  ////////////////////////////////////////////////////////////////////////////
  // mode decode

  bmi_mode_s mode_now; // enables from the mode registers
  bmi_mode_s mode_reg; // enables held for the burst
  bmi_mode_s mode_next;

  // map mode register bits onto enables
  always_comb
  begin
    mode_now.rd_inv_en = mr3_op[MR3_RD_INV_BIT];
    mode_now.wr_inv_en = mr3_op[MR3_WR_INV_BIT];
    mode_now.mask_en = !mode_register_thirteen_op[MODE_REGISTER_THIRTEEN_MASK_OFF_BIT];
  end

  ////////////////////////////////////////////////////////////////////////////
  // burst sequencer

  bmi_state_e state_reg, state_next; // burst state
  bmi_cmd_e kind_reg, kind_next; // kind of the running burst
  logic [BEAT_W-1:0] beats_reg, beats_next; // beats still to come
  logic rx_en_next; // pin receiver enable
  logic illegal_next; // illegal command pulse
  logic accept; // command taken this cycle
  logic wr_fire; // write beat sampled
  logic rd_fire; // read beat sent
  logic any_now; // some function on at command time

  assign accept = cmd_valid && (state_reg == ST_IDLE);
  assign wr_fire = (state_reg == ST_WRITE) && strobe_edge;
  assign rd_fire = (state_reg == ST_READ) && rd_beat_valid;

  // start, count and end bursts
  always_comb
  begin
    any_now = mode_now.mask_en | mode_now.wr_inv_en | mode_now.rd_inv_en;
    state_next = state_reg;
    kind_next = kind_reg;
    beats_next = beats_reg;
    mode_next = mode_reg;
    rx_en_next = mi_rx_en;
    illegal_next = 1'b0;
    case (state_reg)
      ST_IDLE:
      begin
        if (accept)
        begin
          kind_next = cmd.kind;
          mode_next = mode_now;
          beats_next = cmd.long_burst ? BEATS_BL32 : BEATS_BL16;
          case (cmd.kind)
            CMD_WRITE, CMD_MRW:
            begin
              state_next = ST_WRITE;
              rx_en_next = mode_now.wr_inv_en;
            end
            CMD_MASK_WRITE:
            begin
              if (mode_now.mask_en)
              begin
                state_next = ST_WRITE;
                rx_en_next = 1'b1;
              end
              else
              begin
                illegal_next = 1'b1;
              end
            end
            CMD_WR_FIFO:
            begin
              state_next = ST_WRITE;
              rx_en_next = any_now;
            end
            CMD_READ, CMD_MRR, CMD_RD_FIFO, CMD_RD_CAL:
            begin
              state_next = ST_READ;
            end
            default:
            begin
              state_next = ST_IDLE;
            end
          endcase
        end
      end
      ST_WRITE, ST_READ:
      begin
        if (wr_fire || rd_fire)
        begin
          beats_next = beats_reg - BEAT_LAST;
          if (beats_reg == BEAT_LAST)
          begin
            state_next = ST_IDLE;
            rx_en_next = 1'b0;
          end
        end
      end
      default:
      begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // sequencer registers
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_reg <= ST_IDLE;
      kind_reg <= CMD_NONE;
      beats_reg <= '0;
      mode_reg <= '0;
      mi_rx_en <= 1'b0;
      illegal_cmd <= 1'b0;
      busy <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      kind_reg <= kind_next;
      beats_reg <= beats_next;
      mode_reg <= mode_next;
      mi_rx_en <= rx_en_next;
      illegal_cmd <= illegal_next;
      busy <= (state_next != ST_IDLE);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // training store for the pin pattern

  logic [LANES-1:0] fifo_mem [FIFO_DEPTH]; // captured pin per beat
  logic [PTR_W-1:0] wptr_reg, wptr_next; // capture index
  logic [PTR_W-1:0] rptr_reg, rptr_next; // replay index
  logic fifo_we; // capture this beat
  logic [LANES-1:0] mi_rx; // pin as seen through the receiver

  assign mi_rx = mi_rx_en ? mi_s2_reg : '0;
  assign fifo_we = wr_fire && (kind_reg == CMD_WR_FIFO);

  // step the capture and replay indices
  always_comb
  begin
    wptr_next = wptr_reg;
    rptr_next = rptr_reg;
    if (accept)
    begin
      wptr_next = (cmd.kind == CMD_WR_FIFO) ? '0 : wptr_reg;
      rptr_next = (cmd.kind == CMD_RD_FIFO) ? '0 : rptr_reg;
    end
    else
    begin
      wptr_next = fifo_we ? wptr_reg + 1'b1 : wptr_reg;
      rptr_next = (rd_fire && kind_reg == CMD_RD_FIFO) ? rptr_reg + 1'b1 : rptr_reg;
    end
  end

  // index registers and the capture store
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wptr_reg <= '0;
      rptr_reg <= '0;
    end
    else
    begin
      wptr_reg <= wptr_next;
      rptr_reg <= rptr_next;
    end
    if (fifo_we)
    begin
      fifo_mem[wptr_reg] <= mi_rx;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-lane decode and encode

  logic [LANES*LANE_W-1:0] dec_data; // decoded write bytes
  logic [LANES-1:0] dec_keep; // write byte enables
  logic [LANES*LANE_W-1:0] enc_data; // encoded read bytes
  logic [LANES-1:0] enc_mi; // pin level per lane
  logic [LANES-1:0] enc_drive; // pin driver per lane
  logic [LANES-1:0] fifo_bits; // replayed pattern

  assign fifo_bits = fifo_mem[rptr_reg];

  // each lane decides on its own beat
  for (genvar g = 0; g < LANES; g++)
  begin : g_lane
    bmi_write_decode u_wdec (
      .mode(mode_reg),
      .kind(kind_reg),
      .data_in(dq_s2_reg[g*LANE_W +: LANE_W]),
      .mi_in(mi_rx[g]),
      .data_out(dec_data[g*LANE_W +: LANE_W]),
      .keep(dec_keep[g])
    );
    bmi_read_encode u_renc (
      .mode(mode_reg),
      .kind(kind_reg),
      .data_in(rd_beat_data[g*LANE_W +: LANE_W]),
      .cal_bit(rd_beat_cal[g]),
      .fifo_bit(fifo_bits[g]),
      .data_out(enc_data[g*LANE_W +: LANE_W]),
      .mi_out(enc_mi[g]),
      .mi_drive(enc_drive[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // output registers

  // one beat in, one registered beat out
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wr_valid <= 1'b0;
      wr_data <= '0;
      wr_keep <= '0;
      rd_dq_valid <= 1'b0;
      rd_dq_out <= '0;
      mi_pin_out <= '0;
      mi_pin_oe <= '0;
    end
    else
    begin
      wr_valid <= wr_fire;
      wr_data <= wr_fire ? dec_data : wr_data;
      wr_keep <= wr_fire ? dec_keep : wr_keep;
      rd_dq_valid <= rd_fire;
      rd_dq_out <= rd_fire ? enc_data : rd_dq_out;
      mi_pin_out <= rd_fire ? enc_mi : '0;
      mi_pin_oe <= rd_fire ? enc_drive : '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence write_cmd_s;
    accept && (cmd.kind inside {CMD_WRITE, CMD_MRW, CMD_WR_FIFO});
  endsequence

  sequence write_busy_s;
    (state_reg == ST_WRITE) && busy;
  endsequence

  write_start_a: assert property (write_cmd_s |=> write_busy_s)
    else $error("write command did not open a burst");

  rx_off_a: assert property (
    (state_reg == ST_WRITE) && (kind_reg inside {CMD_WRITE, CMD_MRW}) && !mode_reg.wr_inv_en
    |-> !mi_rx_en)
    else $error("receiver on during plain write without inversion");

  illegal_mask_a: assert property (
    accept && (cmd.kind == CMD_MASK_WRITE) && mode_register_thirteen_op[MODE_REGISTER_THIRTEEN_MASK_OFF_BIT]
    |=> illegal_cmd && (state_reg == ST_IDLE) ##1 !illegal_cmd)
    else $error("masked write with masking off not refused");

  read_oe_off_a: assert property (
    rd_fire && (kind_reg inside {CMD_READ, CMD_MRR}) && !mode_reg.rd_inv_en
    |=> (mi_pin_oe == '0) && rd_dq_valid)
    else $error("pin driven on read without inversion");

  read_invert_a: assert property (
    rd_fire && (kind_reg == CMD_READ) && mode_reg.rd_inv_en
    && (bmi_ones(rd_beat_data[LANE_W-1:0]) > RD_INV_MORE_THAN)
    |=> mi_pin_out[0] && mi_pin_oe[0]
    && (rd_dq_out[LANE_W-1:0] == ~$past(rd_beat_data[LANE_W-1:0])))
    else $error("read byte not inverted");

  write_invert_a: assert property (
    wr_fire && (kind_reg == CMD_WRITE) && mode_reg.wr_inv_en && mi_s2_reg[0]
    |=> wr_keep[0] && (wr_data[LANE_W-1:0] == ~$past(dq_s2_reg[LANE_W-1:0])))
    else $error("write byte not inverted");

  plain_keep_a: assert property (
    wr_fire && (kind_reg inside {CMD_WRITE, CMD_MRW}) |=> wr_valid && (wr_keep == '1))
    else $error("plain write masked a byte");

  mask_skip_a: assert property (
    wr_fire && (kind_reg == CMD_MASK_WRITE) && !mode_reg.wr_inv_en
    |=> wr_keep[0] == !$past(mi_s2_reg[0]))
    else $error("masked write beat not skipped");

  mask_dbi_a: assert property (
    wr_fire && (kind_reg == CMD_MASK_WRITE) && mode_reg.wr_inv_en && !mi_s2_reg[0]
    && (bmi_ones(dq_s2_reg[LANE_W-1:0] & MASK_FIELD) >= MASK_ONES_MIN)
    |=> !wr_keep[0])
    else $error("inversion-coded mask not honoured");

  fifo_raw_a: assert property (
    wr_fire && (kind_reg == CMD_WR_FIFO) |=> (wr_data == $past(dq_s2_reg)) && (wr_keep == '1))
    else $error("training write data altered");

endmodule
`default_nettype wire

// ### rtl/bmi_pkg.sv
// shared constants, types and helpers for the byte-lane mask/inversion logic
package bmi_pkg;

  // width of one byte lane
  localparam int LANE_W = 8;

  // mode register field positions
  localparam int MR3_RD_INV_BIT = 6;
  localparam int MR3_WR_INV_BIT = 7;
  localparam int MODE_REGISTER_THIRTEEN_MASK_OFF_BIT = 5;

  // read inversion fires when the count of ones is above this
  localparam logic [3:0] RD_INV_MORE_THAN = 4'h4;
  // masked write with inversion masks at this many ones or more
  localparam logic [3:0] MASK_ONES_MIN = 4'h5;
  // bits of the byte that take part in the mask count (bits 7..2)
  localparam logic [LANE_W-1:0] MASK_FIELD = 8'hfc;

  // burst lengths in beats
  localparam int BEAT_W = 6;
  localparam logic [BEAT_W-1:0] BEATS_BL16 = 6'h10;
  localparam logic [BEAT_W-1:0] BEATS_BL32 = 6'h20;
  localparam logic [BEAT_W-1:0] BEAT_LAST = 6'h01;

  // commands that the command decoder hands over
  typedef enum logic [3:0] {
    CMD_NONE,
    CMD_WRITE,
    CMD_MASK_WRITE,
    CMD_MRW,
    CMD_READ,
    CMD_MRR,
    CMD_WR_FIFO,
    CMD_RD_FIFO,
    CMD_RD_CAL
  } bmi_cmd_e;

  // one command with its burst length choice
  typedef struct packed {
    bmi_cmd_e kind;
    logic long_burst;
  } bmi_cmd_s;

  // decoded function enables
  typedef struct packed {
    logic mask_en;
    logic wr_inv_en;
    logic rd_inv_en;
  } bmi_mode_s;

  // count the ones of a byte
  function automatic logic [3:0] bmi_ones(input logic [LANE_W-1:0] b);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < LANE_W; i++)
    begin
      n = n + {3'h0, b[i]};
    end
    return n;
  endfunction

endpackage

// ### rtl/bmi_write_decode.sv
// per-lane decode of one received write beat
`timescale 1ns/1ps
`default_nettype none
module bmi_write_decode
  import bmi_pkg::*;
(
  // function enables and command kind
  input wire bmi_mode_s mode,
  input wire bmi_cmd_e kind,
  // received beat
  input wire logic [LANE_W-1:0] data_in,
  input wire logic mi_in,
  // decoded beat
  output logic [LANE_W-1:0] data_out,
  output logic keep
);

  // decode inversion and masking for one beat of one lane
  always_comb
  begin
    data_out = data_in;
    keep = 1'b1;
    case (kind)
      // plain writes never mask, only invert
      CMD_WRITE, CMD_MRW:
      begin
        if (mode.wr_inv_en && mi_in)
        begin
          data_out = ~data_in;
        end
      end
      CMD_MASK_WRITE:
      begin
        if (!mode.wr_inv_en)
        begin
          // pin high drops the beat
          keep = !mi_in;
        end
        else if (!mi_in && (bmi_ones(data_in & MASK_FIELD) >= MASK_ONES_MIN))
        begin
          // pattern that plain inversion would never send
          keep = 1'b0;
        end
        else if (mi_in)
        begin
          data_out = ~data_in;
        end
      end
      // training data passes untouched
      default:
      begin
        data_out = data_in;
      end
    endcase
  end

endmodule
`default_nettype wire

// ### rtl/bmi_read_encode.sv
// per-lane encode of one outgoing read beat
`timescale 1ns/1ps
`default_nettype none
module bmi_read_encode
  import bmi_pkg::*;
(
  // function enables and command kind
  input wire bmi_mode_s mode,
  input wire bmi_cmd_e kind,
  // beat from the array and training sources
  input wire logic [LANE_W-1:0] data_in,
  input wire logic cal_bit,
  input wire logic fifo_bit,
  // beat toward the pins
  output logic [LANE_W-1:0] data_out,
  output logic mi_out,
  output logic mi_drive
);

  logic any_en; // some function is on

  // choose the pin role and the byte for one beat
  always_comb
  begin
    any_en = mode.mask_en | mode.wr_inv_en | mode.rd_inv_en;
    data_out = data_in;
    mi_out = 1'b0;
    mi_drive = 1'b0;
    case (kind)
      CMD_READ, CMD_MRR:
      begin
        mi_drive = mode.rd_inv_en;
        if (mode.rd_inv_en && (bmi_ones(data_in) > RD_INV_MORE_THAN))
        begin
          data_out = ~data_in;
          mi_out = 1'b1;
        end
      end
      // replay of the captured pin pattern
      CMD_RD_FIFO:
      begin
        mi_drive = any_en;
        mi_out = fifo_bit;
      end
      // calibration pattern on the pin
      CMD_RD_CAL:
      begin
        mi_drive = any_en;
        mi_out = cal_bit;
      end
      default:
      begin
        mi_drive = 1'b0;
      end
    endcase
  end

endmodule
`default_nettype wire

// ### bench/bmi_host_model.sv
// host-side model: drives write strobe, data pins and mask/inversion pins
`timescale 1ns/1ps
`default_nettype none
module bmi_host_model
  import bmi_pkg::*;
#(
  parameter int LANES = 2
)
(
  // clock that paces the pins
  input wire logic clk,
  // pins toward the device
  output logic strobe_pin,
  output logic [LANES*LANE_W-1:0] dq,
  output logic [LANES-1:0] mi
);
  // strobe stands still outside bursts
  initial
  begin
    strobe_pin = 1'b0;
    dq = '0;
    mi = '0;
  end

  //////////////////////////////////////////////////////////////////////////////
  // one beat: pins set one cycle before the strobe edge, held three after
  // four device cycles per strobe edge gives the 200 ns strobe period
  task automatic send_beat(input logic [LANES*LANE_W-1:0] d, input logic [LANES-1:0] m);
    @(posedge clk);
    dq <= d;
    mi <= m;
    @(posedge clk);
    strobe_pin <= ~strobe_pin;
    repeat (2) @(posedge clk);
  endtask

  // released lines show the inverse of their last value, never a stale copy
  task automatic release_pins();
    @(posedge clk);
    dq <= ~dq;
    mi <= ~mi;
  endtask
endmodule
`default_nettype wire

// ### bench/bmi_lane_ctrl_bench.sv
// self-checking bench for the byte-lane mask/inversion control
`timescale 1ns/1ps
`default_nettype none
module bmi_lane_ctrl_bench
  import bmi_pkg::*;
;
  localparam int LN = 2;
  // design inputs
  logic clk, rst, cmd_valid, rd_beat_valid;
  logic [7:0] mr3_op, mode_register_thirteen_op;
  bmi_cmd_s cmd;
  logic strobe_pin;
  logic [15:0] dq_pin_in, rd_beat_data;
  logic [1:0] mi_pin_in, rd_beat_cal;
  // design outputs
  logic [15:0] rd_dq_out, wr_data;
  logic [1:0] mi_pin_out, mi_pin_oe, wr_keep;
  logic rd_dq_valid, mi_rx_en, wr_valid, busy, illegal_cmd;
  // bookkeeping
  int errors, n_compared;
  logic [19:0] seen_q[$];
  logic [1:0] fifo_mi [0:31];

  bmi_host_model #(.LANES(LN)) host (.clk(clk), .strobe_pin(strobe_pin), .dq(dq_pin_in),
    .mi(mi_pin_in));
  bmi_lane_ctrl #(.LANES(LN), .FIFO_DEPTH(32)) dut (.clk(clk), .rst(rst), .mr3_op(mr3_op),
    .mode_register_thirteen_op(mode_register_thirteen_op), .cmd_valid(cmd_valid), .cmd(cmd), .strobe_pin(strobe_pin),
    .dq_pin_in(dq_pin_in), .mi_pin_in(mi_pin_in), .rd_beat_valid(rd_beat_valid),
    .rd_beat_data(rd_beat_data), .rd_beat_cal(rd_beat_cal), .rd_dq_out(rd_dq_out),
    .rd_dq_valid(rd_dq_valid), .mi_pin_out(mi_pin_out), .mi_pin_oe(mi_pin_oe),
    .mi_rx_en(mi_rx_en), .wr_valid(wr_valid), .wr_data(wr_data), .wr_keep(wr_keep),
    .busy(busy), .illegal_cmd(illegal_cmd));

  // 40 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // collect every beat the design hands out: write {00,keep,data}, read {oe,pin,data}
  always @(posedge clk)
  begin
    if (wr_valid === 1'b1)
      seen_q.push_back({2'h0, wr_keep, wr_data});
    else if (rd_dq_valid === 1'b1)
      seen_q.push_back({mi_pin_oe, mi_pin_out, rd_dq_out});
  end

  //////////////////////////////////////////////////////////////////////////////
  // ones in bits 7 down to lo
  function automatic logic [3:0] ones_from(input logic [7:0] b, input int lo);
    logic [3:0] n;
    n = 4'h0;
    for (int i = lo; i < 8; i++)
      n = n + {3'h0, b[i]};
    return n;
  endfunction

  // expected {keep, byte} of one write beat
  function automatic logic [8:0] wexp(bmi_cmd_e k, logic [7:0] d, logic m);
    if (k == CMD_WR_FIFO) return {1'b1, d};
    if (k != CMD_MASK_WRITE) return {1'b1, (mr3_op[7] && m) ? ~d : d};
    if (!mr3_op[7]) return {~m, d};
    if (!m && ones_from(d, 2) >= 4'h5) return {1'b0, d};
    return {1'b1, m ? ~d : d};
  endfunction

  // expected {oe, pin, byte} of one read beat
  function automatic logic [9:0] rexp(bmi_cmd_e k, logic [7:0] d, logic c, logic f);
    logic any;
    any = mr3_op[7] | mr3_op[6] | ~mode_register_thirteen_op[5];
    if (k == CMD_RD_FIFO) return {any, f, d};
    if (k == CMD_RD_CAL) return {any, c, d};
    if (!mr3_op[6]) return {2'b00, d};
    return (ones_from(d, 0) > 4'h4) ? {2'b11, ~d} : {2'b10, d};
  endfunction

  // compare and count
  task automatic check(input logic [19:0] seen, input logic [19:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // verdict and end of run
  task automatic tally_and_finish();
    $display("errors=%0d compared=%0d", errors, n_compared);
    if (errors == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // one-cycle command pulse with mode settings
  task automatic issue(bmi_cmd_e k, logic lng, logic [7:0] m3, logic [7:0] m13);
    @(posedge clk);
    mr3_op <= m3;
    mode_register_thirteen_op <= m13;
    cmd_valid <= 1'b1;
    cmd <= {k, lng};
    @(posedge clk);
    cmd_valid <= 1'b0;
    @(negedge clk);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // full burst of any kind, rx is the expected receiver state for write kinds
  task automatic burst(bmi_cmd_e k, logic lng, logic [7:0] m3, logic [7:0] m13, logic rx);
    int nb;
    logic [7:0] bb;
    logic [15:0] d;
    logic [1:0] m;
    logic [8:0] w;
    logic [9:0] r;
    logic [19:0] e, msk;
    logic [19:0] eq[$], mq[$];
    logic wr;
    nb = lng ? 32 : 16;
    wr = k inside {CMD_WRITE, CMD_MASK_WRITE, CMD_MRW, CMD_WR_FIFO};
    seen_q.delete();
    issue(k, lng, m3, m13);
    check({19'h0, busy}, 20'h1);
    if (wr)
      check({19'h0, mi_rx_en}, {19'h0, rx});
    for (int b = 0; b < nb; b++)
    begin
      bb = b[7:0];
      d = {8'h9d ^ (8'h1f * bb), 8'h35 + 8'h2b * bb};
      m = {bb[0] ^ bb[2], bb[1]};
      if (k inside {CMD_WRITE, CMD_MRW} && !m3[7] && !m13[5])
        m = 2'h0;
      // every fourth masked beat carries five or more ones in bits 7..2 of lane 0 with the pin low
      if (k == CMD_MASK_WRITE && bb[1:0] == 2'h3)
      begin
        d = {8'hfc ^ bb, 8'h7c};
        m = 2'h0;
      end
      e = 20'h0;
      msk = 20'h0;
      for (int g = 0; g < LN; g++)
      begin
        if (wr)
        begin
          w = wexp(k, d[8*g+:8], m[g]);
          e[16+g] = w[8];
          e[8*g+:8] = w[7:0];
          msk[16+g] = 1'b1;
          msk[8*g+:8] = {8{w[8]}};
        end
        else
        begin
          r = rexp(k, d[8*g+:8], m[g], fifo_mi[b][g]);
          e[18+g] = r[9];
          e[16+g] = r[8];
          e[8*g+:8] = r[7:0];
          msk[18+g] = 1'b1;
          msk[16+g] = r[9];
          msk[8*g+:8] = 8'hff;
        end
      end
      eq.push_back(e & msk);
      mq.push_back(msk);
      if (wr)
      begin
        if (k == CMD_WR_FIFO && rx)
          fifo_mi[b] = m;
        host.send_beat(d, m);
      end
      else
      begin
        @(posedge clk);
        rd_beat_valid <= 1'b1;
        rd_beat_data <= d;
        rd_beat_cal <= m;
      end
    end
    if (wr)
      host.release_pins();
    else
    begin
      @(posedge clk);
      rd_beat_valid <= 1'b0;
      rd_beat_data <= ~rd_beat_data;
    end
    for (int i = 0; i < 40 && busy !== 1'b0; i++)
      @(negedge clk);
    if (busy !== 1'b0)
    begin
      errors++;
      tally_and_finish();
    end
    repeat (2) @(posedge clk);
    check(20'(seen_q.size()), 20'(nb));
    for (int i = 0; i < nb && i < seen_q.size(); i++)
      check(seen_q[i] & mq[i], eq[i]);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic s_write_inv();
    burst(CMD_WRITE, 1'b0, 8'h80, 8'h20, 1'b1);
    burst(CMD_MRW, 1'b0, 8'hc0, 8'h00, 1'b1);
  endtask

  task automatic s_write_plain();
    burst(CMD_WRITE, 1'b0, 8'h40, 8'h20, 1'b0);
    burst(CMD_MRW, 1'b0, 8'h00, 8'h00, 1'b0);
  endtask

  task automatic s_mask();
    burst(CMD_MASK_WRITE, 1'b1, 8'h00, 8'h00, 1'b1);
    burst(CMD_MASK_WRITE, 1'b0, 8'h80, 8'h00, 1'b1);
  endtask

  task automatic s_refused();
    issue(CMD_MASK_WRITE, 1'b0, 8'hc0, 8'h20);
    check({18'h0, illegal_cmd, busy}, 20'h2);
    @(negedge clk);
    check({18'h0, illegal_cmd, busy}, 20'h0);
  endtask

  task automatic s_read();
    burst(CMD_READ, 1'b0, 8'h40, 8'h20, 1'b0);
    burst(CMD_MRR, 1'b0, 8'h80, 8'h00, 1'b0);
  endtask

  task automatic s_training();
    burst(CMD_WR_FIFO, 1'b0, 8'h00, 8'h20, 1'b0);
    burst(CMD_WR_FIFO, 1'b0, 8'h80, 8'h20, 1'b1);
    burst(CMD_RD_FIFO, 1'b0, 8'h40, 8'h20, 1'b0);
    burst(CMD_RD_FIFO, 1'b0, 8'h00, 8'h20, 1'b0);
    burst(CMD_RD_CAL, 1'b0, 8'h00, 8'h00, 1'b0);
    burst(CMD_RD_CAL, 1'b0, 8'h00, 8'h20, 1'b0);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    errors = 0;
    n_compared = 0;
    rst = 1'b1;
    cmd_valid = 1'b0;
    cmd = {CMD_NONE, 1'b0};
    mr3_op = 8'h00;
    mode_register_thirteen_op = 8'h20;
    rd_beat_valid = 1'b0;
    rd_beat_data = 16'h0000;
    rd_beat_cal = 2'h0;
    for (int i = 0; i < 32; i++)
      fifo_mi[i] = 2'h0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    s_write_inv();
    s_write_plain();
    s_mask();
    s_refused();
    s_read();
    s_training();
    tally_and_finish();
  end
endmodule
`default_nettype wire
